// >>> pkg/scp_pkg.sv
package scp_pkg;
  localparam int ADDR_W = 13;
  localparam int INSTR_BITS = 16;
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_CHIP_ID = 13'h0001;
  localparam logic [ADDR_W-1:0] ADDR_CHIP_GRADE = 13'h0002;
  localparam logic [ADDR_W-1:0] ADDR_INDEX_A = 13'h0004;
  localparam logic [ADDR_W-1:0] ADDR_INDEX_B = 13'h0005;
  localparam logic [ADDR_W-1:0] ADDR_PROG_FIRST = 13'h0008;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CFG = 13'h0009;
  localparam logic [ADDR_W-1:0] ADDR_PROG_LAST = 13'h002d;
  localparam logic [ADDR_W-1:0] ADDR_UPDATE = 13'h00ff;
  localparam logic [7:0] UPDATE_CMD = 8'h01;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] CLOCK_CFG_RST = 8'h01;
  localparam logic [7:0] PROG_RST = 8'h00;
  localparam int PORT_LSB_BIT_A = 6;
  localparam int PORT_LSB_BIT_B = 1;
  localparam int PORT_SRST_BIT_A = 5;
  localparam int PORT_SRST_BIT_B = 2;
  localparam int CLOCK_DCS_BIT = 0;
  localparam int NUM_PROG = 38;
  localparam logic [1:0] LEN_STREAM = 2'h3;
endpackage

// >>> pkg/scp_reg_if.sv
`timescale 1ns/10ps
// Register access between serial engine and register file
interface scp_reg_if;
  import scp_pkg::*;
  logic wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic lsb_first;
  modport engine(output wr_stb, output addr, output wdata,
                 input rdata, input lsb_first);
  modport regs(input wr_stb, input addr, input wdata,
               output rdata, output lsb_first);
endinterface

// >>> hdl/scp_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for the three pin inputs
module scp_sync #(
  parameter int W = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scp_sync_st_t;
  scp_sync_st_t st_reg, st_next;
  // First stage feeds only the second
  always_comb begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    if (!rst_n_in) begin
      st_next.s1 = rst_val_in;
      st_next.s2 = rst_val_in;
    end
  end
  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end
  assign sync_out = st_reg.s2;
endmodule // scp_sync

// >>> hdl/scp_regs.sv
`timescale 1ns/10ps
// Byte register file with shadow stage and update strobe
module scp_regs #(
  parameter logic [7:0] CHIP_ID_VAL = 8'h5a, // Arbitrary value
  parameter logic [7:0] CHIP_GRADE_VAL = 8'h00 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  scp_reg_if.regs rif,
  output logic dcs_enable_out,
  output logic [7:0] index_a_out,
  output logic [7:0] index_b_out
);
  import scp_pkg::*;
  typedef struct packed {
    logic [7:0] port_cfg;
    logic [7:0] idx_a;
    logic [7:0] idx_b;
    logic [NUM_PROG-1:0][7:0] shadow;
    logic [NUM_PROG-1:0][7:0] active;
  } scp_regs_st_t;
  scp_regs_st_t st_reg, st_next;
  logic in_prog;
  logic [5:0] pidx;
  logic [ADDR_W-1:0] poff;
  logic soft_rst;
  assign in_prog = rif.addr >= ADDR_PROG_FIRST &&
                   rif.addr <= ADDR_PROG_LAST;
  assign poff = rif.addr - ADDR_PROG_FIRST;
  assign pidx = poff[5:0];
  assign soft_rst = rif.wr_stb && rif.addr == ADDR_PORT_CFG &&
                    (rif.wdata[PORT_SRST_BIT_A] || rif.wdata[PORT_SRST_BIT_B]);
  // Writes: direct for unbuffered, shadow for the rest
  always_comb begin
    st_next = st_reg;
    if (rif.wr_stb) begin
      if (rif.addr == ADDR_PORT_CFG) begin
        st_next.port_cfg = rif.wdata;
      end else if (rif.addr == ADDR_INDEX_A) begin
        st_next.idx_a = rif.wdata;
      end else if (rif.addr == ADDR_INDEX_B) begin
        st_next.idx_b = rif.wdata;
      end else if (in_prog) begin
        st_next.shadow[pidx] = rif.wdata;
      end else if (rif.addr == ADDR_UPDATE && rif.wdata == UPDATE_CMD) begin
        st_next.active = st_reg.shadow;
      end
    end
    // Soft reset and pin reset both reload defaults
    if (!rst_n_in || soft_rst) begin
      st_next.port_cfg = PORT_CFG_RST;
      st_next.idx_a = PROG_RST;
      st_next.idx_b = PROG_RST;
      for (int i = 0; i < NUM_PROG; i++) begin
        st_next.shadow[i] = PROG_RST;
        st_next.active[i] = PROG_RST;
      end
      st_next.shadow[1] = CLOCK_CFG_RST;
      st_next.active[1] = CLOCK_CFG_RST;
    end
  end
  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end
  // Readback shows effective values
  always_comb begin
    rif.rdata = 8'h00;
    if (rif.addr == ADDR_PORT_CFG) begin
      rif.rdata = st_reg.port_cfg;
    end else if (rif.addr == ADDR_CHIP_ID) begin
      rif.rdata = CHIP_ID_VAL;
    end else if (rif.addr == ADDR_CHIP_GRADE) begin
      rif.rdata = CHIP_GRADE_VAL;
    end else if (rif.addr == ADDR_INDEX_A) begin
      rif.rdata = st_reg.idx_a;
    end else if (rif.addr == ADDR_INDEX_B) begin
      rif.rdata = st_reg.idx_b;
    end else if (in_prog) begin
      rif.rdata = st_reg.active[pidx];
    end
  end
  // Mirrored bits: either copy selects LSB first
  assign rif.lsb_first = st_reg.port_cfg[PORT_LSB_BIT_A] ||
                         st_reg.port_cfg[PORT_LSB_BIT_B];
  assign dcs_enable_out = st_reg.active[1][CLOCK_DCS_BIT];
  assign index_a_out = st_reg.idx_a;
  assign index_b_out = st_reg.idx_b;
endmodule // scp_regs

// >>> hdl/scp_top.sv
`timescale 1ns/10ps
// Function
// - Frame starts: select low, then clock rise
// - 16-bit instruction, length field sets bytes
// - Select may pause between whole bytes
// - Length 11 streams until select rises
// - Select rising mid-byte resets engine
// - Select held high: pins take secondary use
// - Select tied low gives two-wire mode
// - Without select, streaming never ends
// - Instruction picks write or readback
// - Data pin driven only during readback
// - Sample on rise, drive after fall
// - MSB first default, config selects LSB for data bytes
// - Byte registers, documented address groups
// - Shadow writes apply on 0x01 to 0xFF
// - 0x00, 0x04, 0x05, 0xFF are direct
// - Clock register resets 0x01, bit0 stabilizer
// - Reset loads default register values
module scp_top #(
  parameter logic [7:0] CHIP_ID_VAL = 8'h5a, // Arbitrary value
  parameter logic [7:0] CHIP_GRADE_VAL = 8'h00 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_n_in,
  input wire logic sclk_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output logic secondary_mode_out,
  output logic secondary_sclk_out,
  output logic secondary_sdio_out,
  output logic dcs_enable_out,
  output logic [7:0] index_a_out,
  output logic [7:0] index_b_out
);
  import scp_pkg::*;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA = 2'b01,
    ST_IDLE = 2'b10
  } scp_state_t;

  typedef struct packed {
    scp_state_t state;
    logic [INSTR_BITS-1:0] shift;
    logic [4:0] bit_cnt;
    logic read;
    logic [1:0] len;
    logic [ADDR_W-1:0] addr;
    logic [1:0] bytes_done;
    logic [7:0] tx;
    logic drive;
    logic sdo;
    logic sclk_d;
    logic csn_d;
  } scp_st_t;

  scp_st_t st_reg, st_next;
  logic [2:0] pins_sync;
  logic csn_s, sclk_s, sdio_s;
  logic sclk_rise, sclk_fall, csn_rise, csn_fall;
  logic [7:0] rx_byte;
  logic [7:0] tx_bit_sel;
  logic lsb_first;
  logic [7:0] wbyte;
  logic last_byte;

  scp_reg_if rif ();

  // Pins are asynchronous to clk_in
  scp_sync #(
    .W(3)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({chip_select_n_in, sclk_in, sdio_in}),
    .rst_val_in(3'h4),
    .sync_out(pins_sync)
  );
  assign csn_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign sdio_s = pins_sync[0];

  scp_regs #(
    .CHIP_ID_VAL(CHIP_ID_VAL),
    .CHIP_GRADE_VAL(CHIP_GRADE_VAL)
  ) u_regs (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .rif(rif),
    .dcs_enable_out(dcs_enable_out),
    .index_a_out(index_a_out),
    .index_b_out(index_b_out)
  );

  // Edge finders on synchronised copies only
  assign sclk_rise = sclk_s && !st_reg.sclk_d;
  assign sclk_fall = !sclk_s && st_reg.sclk_d;
  assign csn_rise = csn_s && !st_reg.csn_d;
  assign csn_fall = !csn_s && st_reg.csn_d;
  assign lsb_first = rif.lsb_first;

  // Bit reversal used for both directions
  function automatic logic [7:0] scp_order(input logic [7:0] b,
                                           input logic lsb);
    logic [7:0] r;
    r = b;
    if (lsb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7-i];
      end
    end
    return r;
  endfunction

  // Byte just completed, incoming bit included
  assign rx_byte = scp_order({st_reg.shift[6:0], sdio_s}, lsb_first);
  assign wbyte = rx_byte;
  assign last_byte = st_reg.len != LEN_STREAM &&
                     st_reg.bytes_done == st_reg.len;
  assign tx_bit_sel = scp_order(rif.rdata, lsb_first);

  // Register port: address always follows the engine
  always_comb begin
    rif.addr = st_reg.addr;
    rif.wdata = wbyte;
    rif.wr_stb = st_reg.state == ST_DATA && !st_reg.read && !csn_s &&
                 sclk_rise && st_reg.bit_cnt[2:0] == BYTE_LAST;
  end

  // Serial engine
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = sclk_s;
    st_next.csn_d = csn_s;
    if (csn_rise && st_reg.bit_cnt[2:0] != 3'h0) begin
      // Partial byte abandons the frame
      st_next.state = ST_INSTR;
      st_next.bit_cnt = 5'h00;
      st_next.drive = 1'b0;
    end else if (csn_s) begin
      // Between whole bytes state is held for a resume, except a stream, which ends below
      st_next.drive = 1'b0;
    end else if (sclk_rise) begin
      st_next.shift = {st_reg.shift[INSTR_BITS-2:0], sdio_s};
      st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      if (st_reg.drive) begin
        st_next.drive = 1'b0;
      end
      unique case (st_reg.state)
        ST_INSTR: begin
          if (st_reg.bit_cnt == INSTR_LAST) begin
            // Instruction is always MSB first in this build
            st_next.read = st_reg.shift[14];
            st_next.len = st_reg.shift[13:12];
            st_next.addr = {st_reg.shift[11:0], sdio_s};
            st_next.bytes_done = 2'h0;
            st_next.bit_cnt = 5'h00;
            st_next.state = ST_DATA;
          end
        end
        ST_DATA: begin
          if (st_reg.bit_cnt[2:0] == BYTE_LAST) begin
            st_next.bit_cnt = 5'h00;
            st_next.addr = st_reg.addr + 13'h0001;
            if (last_byte) begin
              st_next.state = ST_INSTR;
            end else if (st_reg.len != LEN_STREAM) begin
              st_next.bytes_done = st_reg.bytes_done + 2'h1;
            end
            // Streaming only stops on select rising
          end
        end
        default: begin
          st_next.state = ST_INSTR;
        end
      endcase
    end else if (sclk_fall && st_reg.state == ST_DATA && st_reg.read) begin
      // Drive next read bit after the falling edge
      if (st_reg.bit_cnt[2:0] == 3'h0) begin
        st_next.tx = {tx_bit_sel[6:0], 1'b0};
        st_next.sdo = tx_bit_sel[7];
      end else begin
        st_next.tx = {st_reg.tx[6:0], 1'b0};
        st_next.sdo = st_reg.tx[7];
      end
      st_next.drive = 1'b1;
    end else if (csn_fall && st_reg.state == ST_DATA && st_reg.read &&
                 st_reg.bit_cnt[2:0] == 3'h0) begin
      // Resume after a stall: the falling edge was lost under select high
      st_next.tx = {tx_bit_sel[6:0], 1'b0};
      st_next.sdo = tx_bit_sel[7];
      st_next.drive = 1'b1;
    end else if (sclk_fall && st_reg.state == ST_INSTR &&
                 st_reg.bit_cnt == 5'h10) begin
      st_next.drive = 1'b0;
    end
    if (csn_rise && st_reg.bit_cnt[2:0] == 3'h0 &&
        st_reg.state == ST_DATA && st_reg.len == LEN_STREAM) begin
      st_next.state = ST_INSTR;
    end
    if (!rst_n_in) begin
      st_next.state = ST_INSTR;
      st_next.shift = '0;
      st_next.bit_cnt = 5'h00;
      st_next.read = 1'b0;
      st_next.len = 2'h0;
      st_next.addr = '0;
      st_next.bytes_done = 2'h0;
      st_next.tx = 8'h00;
      st_next.drive = 1'b0;
      st_next.sdo = 1'b0;
      st_next.sclk_d = 1'b0;
      st_next.csn_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end

  // Tied-low select simply leaves the engine armed
  assign sdio_out = st_reg.sdo;
  assign sdio_oe_out = st_reg.drive && st_reg.read;
  // Select high hands pins to their secondary use
  assign secondary_mode_out = csn_s;
  assign secondary_sclk_out = csn_s & sclk_s;
  assign secondary_sdio_out = csn_s & sdio_s;

  // Checks
  property p_oe_only_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      sdio_oe_out |-> st_reg.read && st_reg.state == ST_DATA;
  endproperty
  a_oe_only_read: assert property (p_oe_only_read)
    else $error("data pin driven outside readback");

  property p_oe_off_select;
    @(posedge clk_in) disable iff (!rst_n_in)
      csn_s |=> !sdio_oe_out;
  endproperty
  a_oe_off_select: assert property (p_oe_off_select)
    else $error("data pin driven with select high");

  property p_oe_on_fall;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(sdio_oe_out) |->
        $past(sclk_fall) || $past(csn_fall && !sclk_s);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("drive began away from falling clock");

  property p_abort_mid;
    @(posedge clk_in) disable iff (!rst_n_in)
      csn_rise && st_reg.bit_cnt[2:0] != 3'h0 |=>
        st_reg.state == ST_INSTR && st_reg.bit_cnt == 5'h00;
  endproperty
  a_abort_mid: assert property (p_abort_mid)
    else $error("partial byte did not reset engine");

  property p_instr_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_reg.state == ST_INSTR && !csn_s && sclk_rise &&
      st_reg.bit_cnt == INSTR_LAST |=> st_reg.state == ST_DATA;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("no data phase after sixteen bits");

  property p_addr_step;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_reg.state == ST_DATA && !csn_s && sclk_rise &&
      st_reg.bit_cnt[2:0] == BYTE_LAST |=>
        st_reg.addr == $past(st_reg.addr) + 13'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step");

  property p_stream_holds;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_reg.state == ST_DATA && st_reg.len == LEN_STREAM && !csn_s |=>
        st_reg.state == ST_DATA;
  endproperty
  a_stream_holds: assert property (p_stream_holds)
    else $error("stream ended with select low");

  property p_write_only;
    @(posedge clk_in) disable iff (!rst_n_in)
      rif.wr_stb |-> !st_reg.read;
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("write strobe in readback frame");

  property p_dcs_reset;
    @(posedge clk_in)
      !rst_n_in |=> dcs_enable_out;
  endproperty
  a_dcs_reset: assert property (p_dcs_reset)
    else $error("stabilizer not on after reset");

  property p_secondary;
    @(posedge clk_in) disable iff (!rst_n_in)
      secondary_mode_out && st_reg.csn_d |=>
        st_reg.bit_cnt == $past(st_reg.bit_cnt) &&
        st_reg.state == $past(st_reg.state);
  endproperty
  a_secondary: assert property (p_secondary)
    else $error("engine moved while pins in secondary use");

  property p_last_byte;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_reg.state == ST_DATA && !csn_s && sclk_rise &&
      st_reg.bit_cnt[2:0] == BYTE_LAST && st_reg.len != LEN_STREAM &&
      st_reg.bytes_done == st_reg.len |=> st_reg.state == ST_INSTR;
  endproperty
  a_last_byte: assert property (p_last_byte)
    else $error("frame outran its length field");

  property p_drive_off_rise;
    @(posedge clk_in) disable iff (!rst_n_in)
      sdio_oe_out && sclk_rise |=> !sdio_oe_out;
  endproperty
  a_drive_off_rise: assert property (p_drive_off_rise)
    else $error("data pin still driven after rising clock");

  property p_index_direct;
    @(posedge clk_in) disable iff (!rst_n_in)
      rif.wr_stb && rif.addr == ADDR_INDEX_A |=>
        index_a_out == $past(rif.wdata);
  endproperty
  a_index_direct: assert property (p_index_direct)
    else $error("direct register did not take the write");

  property p_dcs_buffered;
    @(posedge clk_in) disable iff (!rst_n_in)
      !(rif.wr_stb && (rif.addr == ADDR_UPDATE ||
        rif.addr == ADDR_PORT_CFG)) |=> $stable(dcs_enable_out);
  endproperty
  a_dcs_buffered: assert property (p_dcs_buffered)
    else $error("stabilizer changed without update strobe");

  property p_msb_default;
    @(posedge clk_in)
      !rst_n_in |=> !rif.lsb_first;
  endproperty
  a_msb_default: assert property (p_msb_default)
    else $error("bit order not MSB first after reset");
endmodule // scp_top

// >>> sim/scp_host_model.sv
`timescale 1ns/10ps
// Host side of the three-wire port: drives select, clock and data
module scp_host_model (
  input wire logic clk_in,
  input wire logic sdio_wire_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdio_d_out,
  output logic sdio_en_out,
  output logic rd_window_out
);
  logic two_wire = 1'b0;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];

  // Idle: select high, clock parked low, data released
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdio_d_out = 1'b0;
    sdio_en_out = 1'b0;
    rd_window_out = 1'b0;
  end

  // Step n system clocks, then move off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One 80 ns serial period; read bits taken mid-high, well settled
  task automatic bit_cycle(input logic drive, input logic d, output logic q);
    sdio_en_out = drive;
    sdio_d_out = d;
    wait_clk(4);
    sclk_out = 1'b1;
    wait_clk(2);
    q = sdio_wire_in;
    wait_clk(2);
    sclk_out = 1'b0;
  endtask

  // Whole frame; stall lifts select between complete bytes only
  task automatic xfer(input logic rd, input logic [1:0] len,
                      input logic [12:0] addr, input int n, input logic lsb,
                      input logic stall, input int cut);
    logic [15:0] instr;
    logic q;
    int b;
    int i;
    instr = {rd, len, addr};
    if (!two_wire) begin
      cs_n_out = 1'b0;
      wait_clk(4);
    end
    for (i = 15; i >= 0; i--) begin
      bit_cycle(1'b1, instr[i], q);
    end
    rd_window_out = rd;
    for (b = 0; b < n; b++) begin
      if (stall && b > 0) begin
        cs_n_out = 1'b1;
        wait_clk(12);
        cs_n_out = 1'b0;
        wait_clk(4);
      end
      for (i = 0; i < 8; i++) begin
        bit_cycle(!rd, wbuf[b][lsb ? i : 7 - i], q);
        rbuf[b][lsb ? i : 7 - i] = q;
      end
    end
    // Partial byte left hanging when cut is non-zero
    for (i = 0; i < cut; i++) begin
      bit_cycle(1'b1, 1'b1, q);
    end
    sdio_en_out = 1'b0;
    wait_clk(4);
    if (!two_wire) begin
      cs_n_out = 1'b1;
    end
    wait_clk(12);
    rd_window_out = 1'b0;
  endtask

  // Raw pin levels for secondary use with select high
  task automatic pins(input logic c, input logic d);
    sclk_out = c;
    sdio_en_out = 1'b1;
    sdio_d_out = d;
    wait_clk(6);
  endtask
endmodule // scp_host_model

// >>> sim/serial_config_port_test.sv
`timescale 1ns/10ps
// Self-checking bench for the serial configuration port
module serial_config_port_test;
  import scp_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h36; // Arbitrary value
  localparam logic [7:0] GRADE_VAL = 8'h09; // Arbitrary value
  localparam int LIMIT = 40000;
  typedef struct packed {
    logic rd;
    logic [12:0] addr;
    logic [7:0] val;
  } scp_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, host_d, host_en, rd_window, sdio_wire;
  logic last_bit = 1'b0;
  logic sdio_out, sdio_oe, sec_mode, sec_sclk, sec_sdio, dcs;
  logic [7:0] idx_a, idx_b;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  scp_row_t rows [0:13];

  scp_top #(.CHIP_ID_VAL(ID_VAL), .CHIP_GRADE_VAL(GRADE_VAL)) scp_top_inst (
    .clk_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n),
    .sclk_in(sclk), .sdio_in(sdio_wire), .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe), .secondary_mode_out(sec_mode),
    .secondary_sclk_out(sec_sclk), .secondary_sdio_out(sec_sdio),
    .dcs_enable_out(dcs), .index_a_out(idx_a), .index_b_out(idx_b));

  scp_host_model scp_host_model_inst (
    .clk_in(clk), .sdio_wire_in(sdio_wire), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdio_d_out(host_d), .sdio_en_out(host_en),
    .rd_window_out(rd_window));

  always #5 clk = ~clk;

  // Undriven data line toggles so a stale bit never reads as valid
  assign sdio_wire = sdio_oe ? sdio_out : (host_en ? host_d : ~last_bit);
  always @(posedge clk) last_bit <= sdio_wire;

  // Device may drive data only inside a readback phase; hang guard
  always @(posedge clk) begin
    cycles++;
    if (rst_n && sdio_oe === 1'b1 && rd_window !== 1'b1) begin
      miscompares++;
      $display("BAD sdio_oe expected 0 seen 1");
    end
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic wr1(input logic [12:0] a, input logic [7:0] v,
                     input logic lsb);
    scp_host_model_inst.wbuf[0] = v;
    scp_host_model_inst.xfer(1'b0, 2'h0, a, 1, lsb, 1'b0, 0);
  endtask

  task automatic rd1(input logic [12:0] a, input logic lsb);
    scp_host_model_inst.xfer(1'b1, 2'h0, a, 1, lsb, 1'b0, 0);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rows = '{
      '{1'b0, ADDR_INDEX_A, 8'ha5}, '{1'b1, ADDR_INDEX_A, 8'ha5},
      '{1'b0, ADDR_INDEX_B, 8'h3c}, '{1'b1, ADDR_INDEX_B, 8'h3c},
      '{1'b1, ADDR_PORT_CFG, PORT_CFG_RST},
      '{1'b1, ADDR_CLOCK_CFG, CLOCK_CFG_RST},
      '{1'b1, ADDR_CHIP_ID, ID_VAL}, '{1'b1, ADDR_CHIP_GRADE, GRADE_VAL},
      '{1'b0, 13'h0030, 8'hff}, '{1'b1, 13'h0030, 8'h00},
      '{1'b0, 13'h000a, 8'h77}, '{1'b1, 13'h000a, PROG_RST},
      '{1'b0, ADDR_UPDATE, UPDATE_CMD}, '{1'b1, 13'h000a, 8'h77}};
    do_reset();
    check("dcs", 8'h01, {7'h0, dcs});
    check("idx_a", 8'h00, idx_a);
    // Single-byte register traffic from the table
    foreach (rows[k]) begin
      if (rows[k].rd) begin
        rd1(rows[k].addr, 1'b0);
        check("rd", rows[k].val, scp_host_model_inst.rbuf[0]);
      end else begin
        wr1(rows[k].addr, rows[k].val, 1'b0);
        if (rows[k].addr == ADDR_INDEX_A) begin
          check("idx_a", rows[k].val, idx_a);
        end
      end
    end
    check("idx_b", 8'h3c, idx_b);
    // Three-byte write and two-byte read, select lifted between bytes
    scp_host_model_inst.wbuf = '{8'h61, 8'h62, 8'h63, 0, 0, 0, 0, 0};
    scp_host_model_inst.xfer(1'b0, 2'h2, ADDR_INDEX_A, 3, 1'b0, 1'b1, 0);
    check("idx_a", 8'h61, idx_a);
    check("idx_b", 8'h62, idx_b);
    scp_host_model_inst.xfer(1'b1, 2'h1, ADDR_INDEX_A, 2, 1'b0, 1'b1, 0);
    check("rd0", 8'h61, scp_host_model_inst.rbuf[0]);
    check("rd1", 8'h62, scp_host_model_inst.rbuf[1]);
    // Stream into the clock register, held in shadow until strobe
    scp_host_model_inst.wbuf = '{8'h00, 8'h11, 8'h22, 0, 0, 0, 0, 0};
    scp_host_model_inst.xfer(1'b0, LEN_STREAM, ADDR_CLOCK_CFG, 3, 1'b0,
                             1'b0, 0);
    check("dcs", 8'h01, {7'h0, dcs});
    wr1(ADDR_UPDATE, UPDATE_CMD, 1'b0);
    check("dcs", 8'h00, {7'h0, dcs});
    scp_host_model_inst.xfer(1'b1, LEN_STREAM, ADDR_CLOCK_CFG, 3, 1'b0,
                             1'b0, 0);
    check("st0", 8'h00, scp_host_model_inst.rbuf[0]);
    check("st2", 8'h22, scp_host_model_inst.rbuf[2]);
    // Select rising mid-byte drops the write, next frame still works
    scp_host_model_inst.xfer(1'b0, 2'h0, ADDR_INDEX_A, 0, 1'b0, 1'b0, 5);
    check("idx_a", 8'h61, idx_a);
    wr1(ADDR_INDEX_A, 8'h5e, 1'b0);
    check("idx_a", 8'h5e, idx_a);
    // Mirrored pattern sets both order bits in either order
    wr1(ADDR_PORT_CFG, 8'h5a, 1'b0);
    wr1(ADDR_INDEX_B, 8'h12, 1'b1);
    check("idx_b", 8'h12, idx_b);
    rd1(ADDR_INDEX_B, 1'b1);
    check("rd_lsb", 8'h12, scp_host_model_inst.rbuf[0]);
    // Mirrored soft reset bits reload every default
    wr1(ADDR_PORT_CFG, 8'h24, 1'b1);
    check("idx_b", 8'h00, idx_b);
    check("dcs", 8'h01, {7'h0, dcs});
    rd1(ADDR_PORT_CFG, 1'b0);
    check("cfg", PORT_CFG_RST, scp_host_model_inst.rbuf[0]);
    // Select high hands the pins to their secondary use
    scp_host_model_inst.pins(1'b1, 1'b0);
    check("sec", 8'h06, {5'h0, sec_mode, sec_sclk, sec_sdio});
    scp_host_model_inst.pins(1'b0, 1'b1);
    check("sec", 8'h05, {5'h0, sec_mode, sec_sclk, sec_sdio});
    // Select tied low from reset on: two-wire traffic
    scp_host_model_inst.two_wire = 1'b1;
    scp_host_model_inst.cs_n_out = 1'b0;
    do_reset();
    check("idx_a", 8'h00, idx_a);
    wr1(ADDR_INDEX_A, 8'h44, 1'b0);
    check("idx_a", 8'h44, idx_a);
    // Stream never ends here: a later instruction is taken as data
    scp_host_model_inst.wbuf = '{8'h11, 8'h22, 8'h00, 8'h00, 8'h04, 8'h33,
                                 0, 0};
    scp_host_model_inst.xfer(1'b0, LEN_STREAM, ADDR_INDEX_A, 6, 1'b0,
                             1'b0, 0);
    check("idx_a", 8'h11, idx_a);
    end_sim();
  end
endmodule // serial_config_port_test
